//--- accel_event_status_regs.sv
// Event source, event clear, orientation status and axis output registers.
`timescale 1ns/100ps
// Contract
// - Addresses 0 and 1 read source registers, writes go to separate clear registers.
// - An interrupting event sets its source bit to one.
// - Host writes one to clear; device clears source bit, then the clear bit.
// - Writing zero to a clear bit leaves its source bit alone.
// - Shake flags for +X, -X, +Y, -Y sit at bits 0 to 3.
// - A set shake flag blocks further shake detection until cleared.
// - XY change flag at bit 6, Z change flag at bit 7.
// - Second source: tilt 7, Z 6, XY 5:4, ready 0, bits 3:1 zero.
// - XY code: 00 +X, 01 +Y, 10 -X, 11 -Y.
// - XY code updates only when larger XY magnitude exceeds the limit.
// - Z code holds tilt in upper bit and Z sign in lower bit.
// - Tilt sets tilt bit, freezes XY, reports Z vertical by sign.
// - Filtered codes change only after enough consecutive valid readings.
// - Readings at 100 Hz; count selects 16, 32, 64 or 128.
// - Data-ready sets whenever a new measurement completes.
// - Software reset bit resets the device for the current transfer.
// - Software reset never reaches the bus interface logic.
// - Status shows unfiltered XY in bits 1:0 and Z in 3:2.
// - Calibration-loaded bit 4 rises once loaded and cannot be cleared; the soft reset clears it here.
// - X is 12-bit two's complement split high byte, upper nibble of low.
// - Y at addresses 5 and 6, Z at 7 and 8, same format.
// - Interrupt pin low when any enabled source bit is set.
// - Source bits set regardless of mask enables.
module accel_event_status_regs #(
  parameter int READ_PERIOD = accel_evt_pkg::READ_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register port from the serial interface
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic xfer_active_i,
  output logic [7:0] reg_rdata_o,
  // Measurement and detection inputs
  input wire logic sample_valid_i,
  input wire logic [11:0] accel_x_i,
  input wire logic [11:0] accel_y_i,
  input wire logic [11:0] accel_z_i,
  input wire logic [3:0] shake_event_i,
  input wire logic calib_done_i,
  input wire logic [1:0] orient_consec_count_i,
  input wire logic [7:0] event_enable_a_i,
  input wire logic [2:0] event_enable_b_i,
  // Interrupt pin, open drain
  output logic irq_out_o,
  output logic irq_oe_o,
  // Device control
  output logic soft_reset_o,
  output logic [3:0] shake_block_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  localparam int TICK_W = $clog2(READ_PERIOD + 1);

  logic [7:0] event_source_a;
  logic [7:0] event_clear_a;
  logic sample_ready_flag;
  logic sample_ready_clear;
  logic calib_loaded_flag;
  logic [1:0] xy_orient_instant;
  logic [1:0] z_orient_instant;
  logic [1:0] xy_orient_filtered;
  logic [1:0] z_orient_filtered;
  logic xy_change;
  logic z_change;
  logic [11:0] accel_x_value;
  logic [11:0] accel_y_value;
  logic [11:0] accel_z_value;
  logic [TICK_W-1:0] tick_count;
  logic read_tick;
  logic [1:0] cls_xy;
  logic [1:0] cls_z;
  logic cls_tilt;
  logic [7:0] event_source_b;
  logic [7:0] status_byte;
  logic [7:0] event_set_a;
  logic [7:0] next_source_a;
  logic wr_a;
  logic wr_b;
  logic [7:0] next_rdata;

  assign wr_a = reg_wr_i && reg_addr_i == accel_evt_pkg::ADDR_EVENT_A;
  assign wr_b = reg_wr_i && reg_addr_i == accel_evt_pkg::ADDR_EVENT_B;

  // ----------------------------------------
  // Software reset
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      soft_reset_o <= 1'b0;
    end else if (wr_b && reg_wdata_i[accel_evt_pkg::SOFT_RESET_BIT]) begin
      soft_reset_o <= 1'b1;
    end else if (!xfer_active_i) begin
      soft_reset_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Reading tick
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_count <= '0;
      read_tick <= 1'b0;
    end else if (soft_reset_o) begin
      tick_count <= '0;
      read_tick <= 1'b0;
    end else if (tick_count == TICK_W'(READ_PERIOD - 1)) begin
      tick_count <= '0;
      read_tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      read_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Axis outputs
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accel_x_value <= accel_evt_pkg::RESET_ACCEL;
      accel_y_value <= accel_evt_pkg::RESET_ACCEL;
      accel_z_value <= accel_evt_pkg::RESET_ACCEL;
    end else if (soft_reset_o) begin
      accel_x_value <= accel_evt_pkg::RESET_ACCEL;
      accel_y_value <= accel_evt_pkg::RESET_ACCEL;
      accel_z_value <= accel_evt_pkg::RESET_ACCEL;
    end else if (sample_valid_i) begin
      accel_x_value <= accel_x_i;
      accel_y_value <= accel_y_i;
      accel_z_value <= accel_z_i;
    end
  end

  // ----------------------------------------
  // Orientation
  // ----------------------------------------
  orient_classifier u_classify (
    .x_i(accel_x_value),
    .y_i(accel_y_value),
    .z_i(accel_z_value),
    .xy_code_o(cls_xy),
    .z_code_o(cls_z),
    .tilt_o(cls_tilt)
  );

  orient_debounce u_xy_filter (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(soft_reset_o),
    .tick_i(read_tick),
    .valid_i(!cls_tilt),
    .cand_i(cls_xy),
    .count_sel_i(orient_consec_count_i),
    .filt_o(xy_orient_filtered),
    .change_o(xy_change)
  );

  orient_debounce u_z_filter (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(soft_reset_o),
    .tick_i(read_tick),
    .valid_i(1'b1),
    .cand_i(cls_z),
    .count_sel_i(orient_consec_count_i),
    .filt_o(z_orient_filtered),
    .change_o(z_change)
  );

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xy_orient_instant <= accel_evt_pkg::RESET_ORIENT;
      z_orient_instant <= accel_evt_pkg::RESET_ORIENT;
    end else if (soft_reset_o) begin
      xy_orient_instant <= accel_evt_pkg::RESET_ORIENT;
      z_orient_instant <= accel_evt_pkg::RESET_ORIENT;
    end else if (read_tick) begin
      if (!cls_tilt) begin
        xy_orient_instant <= cls_xy;
      end
      z_orient_instant <= cls_z;
    end
  end

  // ----------------------------------------
  // Event source and clear registers
  // ----------------------------------------
  assign event_set_a = {z_change, xy_change, 2'b00, shake_event_i};
  assign next_source_a = (event_source_a & ~event_clear_a) | event_set_a;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_source_a <= accel_evt_pkg::RESET_BYTE;
    end else if (soft_reset_o) begin
      event_source_a <= accel_evt_pkg::RESET_BYTE;
    end else begin
      event_source_a <= next_source_a;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_clear_a <= accel_evt_pkg::RESET_BYTE;
    end else if (soft_reset_o) begin
      event_clear_a <= accel_evt_pkg::RESET_BYTE;
    end else if (wr_a) begin
      event_clear_a <= reg_wdata_i & accel_evt_pkg::EVENT_A_MASK;
    end else begin
      event_clear_a <= accel_evt_pkg::RESET_BYTE;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_ready_flag <= 1'b0;
      sample_ready_clear <= 1'b0;
    end else if (soft_reset_o) begin
      sample_ready_flag <= 1'b0;
      sample_ready_clear <= 1'b0;
    end else begin
      sample_ready_flag <= (sample_ready_flag & ~sample_ready_clear) | sample_valid_i;
      sample_ready_clear <= wr_b & reg_wdata_i[accel_evt_pkg::READY_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      calib_loaded_flag <= 1'b0;
    end else if (soft_reset_o) begin
      calib_loaded_flag <= 1'b0;
    end else if (calib_done_i) begin
      calib_loaded_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shake_block_o <= 4'h0;
    end else begin
      shake_block_o <= soft_reset_o ? 4'h0 : next_source_a[3:0];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  assign event_source_b = {z_orient_filtered, xy_orient_filtered, 3'b000,
                           sample_ready_flag};
  assign status_byte = {3'b000, calib_loaded_flag, z_orient_instant,
                        xy_orient_instant};

  always_comb begin
    case (reg_addr_i)
      accel_evt_pkg::ADDR_EVENT_A: next_rdata = event_source_a;
      accel_evt_pkg::ADDR_EVENT_B: next_rdata = event_source_b;
      accel_evt_pkg::ADDR_STATUS: next_rdata = status_byte;
      accel_evt_pkg::ADDR_X_HIGH: next_rdata = accel_x_value[11:4];
      accel_evt_pkg::ADDR_X_LOW: next_rdata = {accel_x_value[3:0], 4'h0};
      accel_evt_pkg::ADDR_Y_HIGH: next_rdata = accel_y_value[11:4];
      accel_evt_pkg::ADDR_Y_LOW: next_rdata = {accel_y_value[3:0], 4'h0};
      accel_evt_pkg::ADDR_Z_HIGH: next_rdata = accel_z_value[11:4];
      accel_evt_pkg::ADDR_Z_LOW: next_rdata = {accel_z_value[3:0], 4'h0};
      default: next_rdata = accel_evt_pkg::RESET_BYTE;
    endcase
  end

  // The read port belongs to the bus side and is left alone by the soft reset.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= accel_evt_pkg::RESET_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_out_o <= 1'b0;
      irq_oe_o <= 1'b0;
    end else begin
      irq_out_o <= 1'b0;
      irq_oe_o <= |(event_source_a & event_enable_a_i) |
                  |(event_source_b[2:0] & event_enable_b_i);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_clear_write;
    wr_a && !soft_reset_o && xfer_active_i;
  endsequence

  sequence s_quiet;
    event_set_a == 8'h00 && !soft_reset_o;
  endsequence

  property p_read_source_a;
    reg_rd_i && reg_addr_i == accel_evt_pkg::ADDR_EVENT_A |=> reg_rdata_o == $past(event_source_a);
  endproperty
  a_read_source_a: assert property (p_read_source_a) else $error("source read mismatch");

  property p_clear_done;
    s_clear_write ##1 s_quiet ##1 s_quiet |-> ((event_source_a & $past(event_clear_a)) == 8'h00)
      && event_clear_a == 8'h00;
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("clear sequence failed");

  property p_zero_keeps;
    wr_a && !soft_reset_o ##1 !soft_reset_o |=> ((($past(event_source_a) &
      ~$past(reg_wdata_i, 2)) & ~event_source_a) == 8'h00);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("source bit lost");

  property p_shake_sets;
    !soft_reset_o && shake_event_i != 4'h0 ##1 !soft_reset_o |->
      (event_source_a[3:0] & $past(shake_event_i)) == $past(shake_event_i);
  endproperty
  a_shake_sets: assert property (p_shake_sets) else $error("shake flag not set");

  property p_ready_sets;
    sample_valid_i && !soft_reset_o ##1 !soft_reset_o |->
      sample_ready_flag;
  endproperty
  a_ready_sets: assert property (p_ready_sets) else $error("ready flag not set");

  property p_soft_hold;
    soft_reset_o && xfer_active_i |=> soft_reset_o ##0 event_source_a == 8'h00;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft reset dropped");

  property p_zero_fields;
    reg_rd_i |=> (reg_rdata_o[3:1] == 3'b000 || $past(reg_addr_i) != accel_evt_pkg::ADDR_EVENT_B)
      && (reg_rdata_o[3:0] == 4'h0 || $past(reg_addr_i[0]) || $past(reg_addr_i) < 8'h04
      || $past(reg_addr_i) > 8'h08);
  endproperty
  a_zero_fields: assert property (p_zero_fields) else $error("zero bits set");

  property p_irq_level;
    1'b1 |=> irq_oe_o == ((|($past(event_source_a) & $past(event_enable_a_i))) ||
      (|($past(sample_ready_flag) & $past(event_enable_b_i[0]))));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_calib_sticky;
    calib_loaded_flag && !soft_reset_o |=> calib_loaded_flag;
  endproperty
  a_calib_sticky: assert property (p_calib_sticky) else $error("calibration flag fell");

endmodule : accel_event_status_regs

//--- accel_evt_pkg.sv
// Constants shared by the event, orientation and output register group.
package accel_evt_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_EVENT_A = 8'h00;
  localparam logic [7:0] ADDR_EVENT_B = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_X_HIGH = 8'h03;
  localparam logic [7:0] ADDR_X_LOW = 8'h04;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h05;
  localparam logic [7:0] ADDR_Y_LOW = 8'h06;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h07;
  localparam logic [7:0] ADDR_Z_LOW = 8'h08;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int XY_CHANGE_BIT = 6;
  localparam int Z_CHANGE_BIT = 7;
  localparam int READY_BIT = 0;
  localparam int SOFT_RESET_BIT = 4;
  localparam int CALIB_BIT = 4;
  localparam logic [7:0] EVENT_A_MASK = 8'hcf;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_ORIENT = 2'h0;
  localparam logic [11:0] RESET_ACCEL = 12'h000;

  // ----------------------------------------
  // Orientation codes
  // ----------------------------------------
  localparam logic [1:0] XY_POS_X = 2'h0;
  localparam logic [1:0] XY_POS_Y = 2'h1;
  localparam logic [1:0] XY_NEG_X = 2'h2;
  localparam logic [1:0] XY_NEG_Y = 2'h3;

  // ----------------------------------------
  // Timing and thresholds
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int READ_PERIOD_NS = 10000000;
  localparam int READ_PERIOD_CYCLES = READ_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ORIENT_BASE_COUNT = 16;
  localparam int XY_LIMIT_MILLI_G = 375;
  localparam int SENS_LSB_PER_G = 1024;
  localparam int XY_LIMIT_LSB = XY_LIMIT_MILLI_G * SENS_LSB_PER_G / 1000;

endpackage : accel_evt_pkg

//--- orient_classifier.sv
// Instantaneous orientation decision from one set of axis readings.
`timescale 1ns/100ps
module orient_classifier #(
  parameter int LIMIT_LSB = accel_evt_pkg::XY_LIMIT_LSB
) (
  // Axis readings
  input wire logic signed [11:0] x_i,
  input wire logic signed [11:0] y_i,
  input wire logic signed [11:0] z_i,
  // Orientation codes
  output logic [1:0] xy_code_o,
  output logic [1:0] z_code_o,
  output logic tilt_o
);

  logic [11:0] mag_x;
  logic [11:0] mag_y;
  logic [11:0] mag_max;

  always_comb begin
    mag_x = x_i[11] ? 12'(-x_i) : 12'(x_i);
    mag_y = y_i[11] ? 12'(-y_i) : 12'(y_i);
    mag_max = (mag_x >= mag_y) ? mag_x : mag_y;
    if (mag_x >= mag_y) begin
      xy_code_o = x_i[11] ? accel_evt_pkg::XY_NEG_X : accel_evt_pkg::XY_POS_X;
    end else begin
      xy_code_o = y_i[11] ? accel_evt_pkg::XY_NEG_Y : accel_evt_pkg::XY_POS_Y;
    end
    tilt_o = (mag_max <= 12'(LIMIT_LSB));
    z_code_o = {tilt_o, z_i[11]};
  end

endmodule : orient_classifier

//--- orient_debounce.sv
// Consecutive-reading filter that commits a new orientation code.
`timescale 1ns/100ps
module orient_debounce (
  // Clock and resets
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  // Readings
  input wire logic tick_i,
  input wire logic valid_i,
  input wire logic [1:0] cand_i,
  input wire logic [1:0] count_sel_i,
  // Filtered result
  output logic [1:0] filt_o,
  output logic change_o
);

  logic [1:0] pend;
  logic [7:0] count;
  logic [7:0] needed;

  assign needed = 8'(accel_evt_pkg::ORIENT_BASE_COUNT) << count_sel_i;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      filt_o <= accel_evt_pkg::RESET_ORIENT;
      pend <= accel_evt_pkg::RESET_ORIENT;
      count <= 8'h00;
      change_o <= 1'b0;
    end else if (clear_i) begin
      filt_o <= accel_evt_pkg::RESET_ORIENT;
      pend <= accel_evt_pkg::RESET_ORIENT;
      count <= 8'h00;
      change_o <= 1'b0;
    end else begin
      change_o <= 1'b0;
      if (tick_i) begin
        if (!valid_i || cand_i == filt_o) begin
          count <= 8'h00;
        end else if (cand_i != pend) begin
          pend <= cand_i;
          count <= 8'h01;
        end else if (count + 8'h01 >= needed) begin
          filt_o <= cand_i;
          count <= 8'h00;
          change_o <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

endmodule : orient_debounce

//--- reg_host_model.sv
// Host-side serial interface model that drives the register port.
`timescale 1ns/100ps
module reg_host_model (
  // Clock
  input wire logic clock_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  output logic xfer_active_o
);
  initial begin
    reg_addr_o = 8'h5a;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'ha5;
    xfer_active_o = 1'b0;
  end

  // One byte access; released address and data lines show the inverse of their last value, strobes drop to zero.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int hold);
    @(posedge clock_i);
    #2;
    xfer_active_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(posedge clock_i);
    #2;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    repeat (hold) @(posedge clock_i);
    #2;
    xfer_active_o = 1'b0;
  endtask : access
endmodule : reg_host_model

//--- accel_event_status_regs_tb_top.sv
// Self-checking testbench of the event, orientation and axis register group.
`timescale 1ns/100ps
module accel_event_status_regs_tb_top;
  localparam int RP = 8;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ena_a;
  logic reg_wr, reg_rd, xfer, sample_valid, calib_done, irq_out, irq_oe, soft_reset;
  logic [11:0] ax, ay, az;
  logic [3:0] shake_ev, shake_block, s, k, pc;
  logic [1:0] count_sel;
  logic [2:0] ena_b;
  logic [11:0] v[3];
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [11:0] ox[8] = '{12'h400, 12'h000, 12'hc00, 12'h000, 12'h000, 12'h000, 12'h181, 12'h000};
  logic [11:0] oy[8] = '{12'h000, 12'h400, 12'h000, 12'hc00, 12'h000, 12'h000, 12'h000, 12'he80};
  logic [11:0] oz[8] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h400, 12'hc00, 12'h3e8, 12'hc18};
  logic [3:0] oc[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hb, 4'hf, 4'h0, 4'hc};
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;

  always #10 clock_i = ~clock_i;

  accel_event_status_regs #(.READ_PERIOD(RP)) DUT (
    .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .xfer_active_i(xfer), .reg_rdata_o(reg_rdata),
    .sample_valid_i(sample_valid), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az),
    .shake_event_i(shake_ev), .calib_done_i(calib_done), .orient_consec_count_i(count_sel),
    .event_enable_a_i(ena_a), .event_enable_b_i(ena_b), .irq_out_o(irq_out),
    .irq_oe_o(irq_oe), .soft_reset_o(soft_reset), .shake_block_o(shake_block)
  );

  reg_host_model host (
    .clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .xfer_active_o(xfer)
  );

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("[ERR] read data exp %h got %h mask %h", e, g, m);
    end
  endtask : chk_rd

  task automatic chk_pin(input string name, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", name, e, g);
    end
  endtask : chk_pin

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    host.access(1'b0, a, 8'h3c, 0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, 0);
  endtask : wr

  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #2;
  endtask : tick

  task automatic sample(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    tick(1);
    {ax, ay, az} = {x, y, z};
    sample_valid = 1'b1;
    tick(1);
    sample_valid = 1'b0;
  endtask : sample

  // Read data watcher and hang guard.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (rd_seen) begin
      chk_rd(exp_q[0][7:0], reg_rdata, exp_q[0][15:8]);
      void'(exp_q.pop_front());
    end
    rd_seen <= reg_rd;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    {ax, ay, az, shake_ev, count_sel, ena_a, ena_b} = '0;
    {sample_valid, calib_done} = 2'b00;
    void'($urandom(32'hb828));
    tick(10);
    resetn_i = 1'b1;
    // ----------------------------------------
    // Reset values, unmapped and read-only places
    // ----------------------------------------
    for (int a = 0; a < 9; a++) rd(8'(a), 8'h00, (a == 2) ? 8'hf0 : 8'hff);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    // ----------------------------------------
    // Axis outputs, ready flag and its interrupt
    // ----------------------------------------
    for (int i = 0; i < 4; i++) begin
      ena_b = {2'b00, i[0]};
      v[0] = (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : 12'($urandom);
      v[1] = 12'($urandom);
      v[2] = 12'($urandom);
      sample(v[0], v[1], v[2]);
      tick(2);
      chk_pin("irq_oe", {3'b000, i[0]}, {3'b000, irq_oe});
      chk_pin("irq_out", 4'h0, {3'b000, irq_out});
      for (int j = 0; j < 3; j++) begin
        rd(8'(3 + 2 * j), v[j][11:4], 8'hff);
        rd(8'(4 + 2 * j), {v[j][3:0], 4'h0}, 8'hff);
      end
      rd(8'h01, 8'h01, 8'h0f);
      wr(8'h01, 8'h01);
      rd(8'h01, 8'h00, 8'h0f);
    end
    // ----------------------------------------
    // Shake flags, masks and partial clears
    // ----------------------------------------
    ena_b = 3'h0;
    wr(8'h00, 8'hff);
    for (int i = 0; i < 6; i++) begin
      ena_a = i[0] ? 8'h0f : 8'h00;
      s = 4'($urandom);
      k = 4'($urandom);
      shake_ev = s;
      tick(1);
      shake_ev = 4'h0;
      tick(2);
      chk_pin("shake_block", s, shake_block);
      chk_pin("irq_oe", {3'b000, i[0] & (|s)}, {3'b000, irq_oe});
      rd(8'h00, {4'h0, s}, 8'h0f);
      wr(8'h00, {4'h0, k});
      rd(8'h00, {4'h0, s & ~k}, 8'h0f);
      tick(1);
      chk_pin("shake_block", s & ~k, shake_block);
      wr(8'h00, 8'h0f);
    end
    // ----------------------------------------
    // Orientation codes and consecutive-count filter
    // ----------------------------------------
    ena_a = 8'h00;
    calib_done = 1'b1;
    pc = 4'h0;
    for (int i = 0; i < 8; i++) begin
      count_sel = i[1:0];
      n = 16 << i[1:0];
      wr(8'h00, 8'hc0);
      sample(ox[i], oy[i], oz[i]);
      tick(RP * 4);
      rd(8'h02, {4'h1, oc[i]}, oc[i][3] ? 8'hfc : 8'hff);
      tick(RP * n - 16 - RP * 4 - 4);
      if (i > 0) rd(8'h01, {pc, 4'h0}, 8'hf0);
      tick(56);
      rd(8'h01, {oc[i], 4'h0}, 8'hfe);
      rd(8'h00, {oc[i][3:2] != pc[3:2], oc[i][1:0] != pc[1:0], 6'h0},
         (i > 0) ? 8'hc0 : 8'h00);
      pc = oc[i];
    end
    // ----------------------------------------
    // Calibration flag and software reset
    // ----------------------------------------
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h10, 8'h10);
    shake_ev = 4'h5;
    sample(12'h123, 12'h456, 12'h789);
    shake_ev = 4'h0;
    calib_done = 1'b0;
    fork
      host.access(1'b1, 8'h01, 8'h10, 6);
      begin
        tick(5);
        chk_pin("soft_reset", 4'h1, {3'b000, soft_reset});
      end
    join
    tick(2);
    chk_pin("soft_reset", 4'h0, {3'b000, soft_reset});
    chk_pin("shake_block", 4'h0, shake_block);
    rd(8'h00, 8'h00, 8'hff);
    rd(8'h01, 8'h00, 8'h0f);
    rd(8'h03, 8'h00, 8'hff);
    rd(8'h02, 8'h00, 8'h10);
    calib_done = 1'b1;
    tick(3);
    rd(8'h02, 8'h10, 8'h10);
    tick(3);
    print_verdict();
  end
endmodule : accel_event_status_regs_tb_top
